// >>> pdpc_regs.svh
// Register indices, masks and reset values of the port direction and pull-up block.
// Assumes an AXI4-Lite master that addresses each register as four times its index.
`ifndef PDPC_REGS_SVH
`define PDPC_REGS_SVH

// Register indices; byte address is index shifted left by two
`define PDPC_IDX_PORT6_DIR  16'hffe9
`define PDPC_IDX_PORT7_DIR  16'hffea
`define PDPC_IDX_PORT8_DIR  16'hffeb
`define PDPC_IDX_PORT9_DIR  16'hffec
`define PDPC_IDX_PORT1_PU   16'hffed
`define PDPC_IDX_PORT3_PU   16'hffee
`define PDPC_IDX_PORT5_PU   16'hffef

// Address field carrying the index
`define PDPC_IDX_LSB        2
`define PDPC_IDX_MSB        17
`define PDPC_ADDR_MSB       31

// Data field and implemented bits
`define PDPC_DATA_MSB       7
`define PDPC_STRB_LANE0     0
`define PDPC_FULL_MASK      8'hff
`define PDPC_PORT9_MASK     8'h1f
`define PDPC_PORT3_MASK     8'h3f

// Reset values
`define PDPC_RST_BYTE       8'h00
`define PDPC_RST_WORD       32'h0000_0000

`endif

// >>> pdpc_pkg.sv
// Types shared by the port direction and pull-up block.
// Assumes nothing beyond the register header.
package pdpc_pkg;

    typedef enum logic [1:0]
    {
        PDPC_RESP_OKAY   = 2'b00,
        PDPC_RESP_SLVERR = 2'b10
    } pdpc_resp_e;

    typedef enum logic [1:0]
    {
        PDPC_WR_IDLE = 2'b00,
        PDPC_WR_RESP = 2'b01
    } pdpc_wr_state_e;

    typedef logic [7:0] pdpc_byte_t;

endpackage

// >>> pdpc_pullup_gate.sv
// Per-pin pull-up enable for one 8-pin port, registered.
// Assumes select and direction come from logic on the same clock.
`timescale 1ns/1ps
`include "pdpc_regs.svh"

module pdpc_pullup_gate
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Controls
    input  wire pdpc_pkg::pdpc_byte_t select,
    input  wire pdpc_pkg::pdpc_byte_t direction,
    // Pull-up enables
    output pdpc_pkg::pdpc_byte_t   pullup_en
);
    import pdpc_pkg::*;

    genvar b;
    generate
        for (b = 0; b <= `PDPC_DATA_MSB; b = b + 1)
        begin : g_bit
            logic en_q;
            // Output pin loses its pull-up on the clock after its direction bit goes to 1
            wire  en_d = select[b] & ~direction[b];
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    en_q <= 1'b0;
                else
                    en_q <= en_d;
            end
            assign pullup_en[b] = en_q;
        end
    endgenerate

endmodule // pdpc_pullup_gate

// >>> pdpc_port_config.sv
// Port direction and pull-up configuration registers behind an AXI4-Lite slave.
// Assumes directions of ports 1, 3 and 5 come from neighbouring logic on aclk.
//
// Function
// - Direction bit 0 input, 1 output.
// - Ports 6-8 direction: 8-bit, write-only, reset zero.
// - Port 9 direction writes bits 4-0 only.
// - Port 3 pull-up: bits 5-0 read/write, reset zero.
// - Ports 5, 1 pull-up: 8 bits, reset zero.
`timescale 1ns/1ps
`include "pdpc_regs.svh"

module pdpc_port_config
(
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Directions of the pull-up ports, from neighbouring registers
    input  wire pdpc_pkg::pdpc_byte_t port1_dir_in,
    input  wire pdpc_pkg::pdpc_byte_t port3_dir_in,
    input  wire pdpc_pkg::pdpc_byte_t port5_dir_in,
    // Pin output enables, 1 drives the pin
    output pdpc_pkg::pdpc_byte_t      port6_oe,
    output pdpc_pkg::pdpc_byte_t      port7_oe,
    output pdpc_pkg::pdpc_byte_t      port8_oe,
    output pdpc_pkg::pdpc_byte_t      port9_oe,
    // Pull-up enables
    output pdpc_pkg::pdpc_byte_t      port1_pullup_en,
    output pdpc_pkg::pdpc_byte_t      port3_pullup_en,
    output pdpc_pkg::pdpc_byte_t      port5_pullup_en
);
    import pdpc_pkg::*;

    // Register state
    pdpc_byte_t     port6_direction_q;
    pdpc_byte_t     port7_direction_q;
    pdpc_byte_t     port8_direction_q;
    pdpc_byte_t     port9_direction_q;
    pdpc_byte_t     port1_pullup_select_q;
    pdpc_byte_t     port3_pullup_select_q;
    pdpc_byte_t     port5_pullup_select_q;

    // Write channel state
    logic           aw_full_q;
    logic           w_full_q;
    logic [31:0]    aw_addr_q;
    logic [31:0]    w_data_q;
    logic [3:0]     w_strb_q;
    pdpc_wr_state_e wr_state_q;
    pdpc_resp_e     bresp_q;

    // Read channel state
    logic           rvalid_q;
    logic [31:0]    rdata_q;
    pdpc_resp_e     rresp_q;

    // Write decode on the held address
    wire [15:0] aw_idx     = aw_addr_q[`PDPC_IDX_MSB:`PDPC_IDX_LSB];
    wire        aw_hi_zero = (aw_addr_q[`PDPC_ADDR_MSB:`PDPC_IDX_MSB+1] == '0);
    wire        wsel_p6    = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT6_DIR);
    wire        wsel_p7    = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT7_DIR);
    wire        wsel_p8    = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT8_DIR);
    wire        wsel_p9    = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT9_DIR);
    wire        wsel_pu1   = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT1_PU);
    wire        wsel_pu3   = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT3_PU);
    wire        wsel_pu5   = aw_hi_zero && (aw_idx == `PDPC_IDX_PORT5_PU);
    wire        wsel_hit   = wsel_p6 | wsel_p7 | wsel_p8 | wsel_p9
                           | wsel_pu1 | wsel_pu3 | wsel_pu5;

    // Write commit once both halves are held and no response is pending
    wire        wr_fire    = aw_full_q && w_full_q && (wr_state_q == PDPC_WR_IDLE);
    // Only the low byte lane carries register data
    wire        wr_lane0   = wr_fire && w_strb_q[`PDPC_STRB_LANE0];
    wire [7:0]  wr_byte    = w_data_q[`PDPC_DATA_MSB:0];

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign s_axi_bvalid  = (wr_state_q == PDPC_WR_RESP);
    assign s_axi_bresp   = bresp_q;

    // Address and data taken independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= `PDPC_RST_WORD;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_full_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            w_data_q <= `PDPC_RST_WORD;
            w_strb_q <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_full_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_q <= PDPC_WR_IDLE;
            bresp_q    <= PDPC_RESP_OKAY;
        end
        else
        begin
            case (wr_state_q)
                PDPC_WR_IDLE:
                    if (wr_fire)
                    begin
                        wr_state_q <= PDPC_WR_RESP;
                        bresp_q    <= wsel_hit ? PDPC_RESP_OKAY : PDPC_RESP_SLVERR;
                    end
                PDPC_WR_RESP:
                    if (s_axi_bready)
                        wr_state_q <= PDPC_WR_IDLE;
                default:
                    wr_state_q <= PDPC_WR_IDLE;
            endcase
        end
    end

    // Direction registers, all inputs after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port6_direction_q <= `PDPC_RST_BYTE;
            port7_direction_q <= `PDPC_RST_BYTE;
            port8_direction_q <= `PDPC_RST_BYTE;
            port9_direction_q <= `PDPC_RST_BYTE;
        end
        else if (wr_lane0)
        begin
            if (wsel_p6)
                port6_direction_q <= wr_byte;
            if (wsel_p7)
                port7_direction_q <= wr_byte;
            if (wsel_p8)
                port8_direction_q <= wr_byte;
            if (wsel_p9)
                port9_direction_q <= wr_byte & `PDPC_PORT9_MASK;
        end
    end

    // Pull-up selection registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port1_pullup_select_q <= `PDPC_RST_BYTE;
            port3_pullup_select_q <= `PDPC_RST_BYTE;
            port5_pullup_select_q <= `PDPC_RST_BYTE;
        end
        else if (wr_lane0)
        begin
            if (wsel_pu1)
                port1_pullup_select_q <= wr_byte;
            if (wsel_pu3)
                port3_pullup_select_q <= wr_byte & `PDPC_PORT3_MASK;
            if (wsel_pu5)
                port5_pullup_select_q <= wr_byte;
        end
    end

    // Read decode straight from the offered address
    wire [15:0] ar_idx     = s_axi_araddr[`PDPC_IDX_MSB:`PDPC_IDX_LSB];
    wire        ar_hi_zero = (s_axi_araddr[`PDPC_ADDR_MSB:`PDPC_IDX_MSB+1] == '0);
    wire        rsel_pu1   = ar_hi_zero && (ar_idx == `PDPC_IDX_PORT1_PU);
    wire        rsel_pu3   = ar_hi_zero && (ar_idx == `PDPC_IDX_PORT3_PU);
    wire        rsel_pu5   = ar_hi_zero && (ar_idx == `PDPC_IDX_PORT5_PU);
    // Write-only registers answer OKAY with zero data
    wire        rsel_wo    = ar_hi_zero && ((ar_idx == `PDPC_IDX_PORT6_DIR)
                           || (ar_idx == `PDPC_IDX_PORT7_DIR)
                           || (ar_idx == `PDPC_IDX_PORT8_DIR)
                           || (ar_idx == `PDPC_IDX_PORT9_DIR));
    wire        rsel_hit   = rsel_pu1 | rsel_pu3 | rsel_pu5 | rsel_wo;
    wire [7:0]  rd_byte    = rsel_pu1 ? port1_pullup_select_q :
                             rsel_pu3 ? (port3_pullup_select_q & `PDPC_PORT3_MASK) :
                             rsel_pu5 ? port5_pullup_select_q :
                                        `PDPC_RST_BYTE;
    wire        ar_fire    = s_axi_arvalid && s_axi_arready;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= `PDPC_RST_WORD;
            rresp_q  <= PDPC_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rsel_hit ? PDPC_RESP_OKAY : PDPC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Pins drive when their direction bit is 1
    assign port6_oe = port6_direction_q;
    assign port7_oe = port7_direction_q;
    assign port8_oe = port8_direction_q;
    assign port9_oe = port9_direction_q;

    pdpc_pullup_gate u_pu1
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .select    (port1_pullup_select_q),
        .direction (port1_dir_in),
        .pullup_en (port1_pullup_en)
    );

    pdpc_pullup_gate u_pu3
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .select    (port3_pullup_select_q),
        .direction (port3_dir_in),
        .pullup_en (port3_pullup_en)
    );

    pdpc_pullup_gate u_pu5
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .select    (port5_pullup_select_q),
        .direction (port5_dir_in),
        .pullup_en (port5_pullup_en)
    );

endmodule // pdpc_port_config

// >>> pdpc_port_config_assertions.sv
// Concurrent checks on the port configuration block, bound to its ports.
// Assumes the register header for the register indices.
`timescale 1ns/1ps
`include "pdpc_regs.svh"
module pdpc_port_config_assertions
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // Pins
    input wire logic [7:0]  port1_dir_in,
    input wire logic [7:0]  port3_dir_in,
    input wire logic [7:0]  port5_dir_in,
    input wire logic [7:0]  port6_oe,
    input wire logic [7:0]  port7_oe,
    input wire logic [7:0]  port8_oe,
    input wire logic [7:0]  port9_oe,
    input wire logic [7:0]  port1_pullup_en,
    input wire logic [7:0]  port3_pullup_en,
    input wire logic [7:0]  port5_pullup_en
);
    localparam logic [31:0] A6 = {14'h0, `PDPC_IDX_PORT6_DIR, 2'h0};
    localparam logic [31:0] A9 = {14'h0, `PDPC_IDX_PORT9_DIR, 2'h0};
    localparam logic [31:0] A3 = {14'h0, `PDPC_IDX_PORT3_PU, 2'h0};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_at(logic [31:0] a);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == a && s_axi_wstrb[0];
    endsequence
    sequence rd_at(logic [31:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    dir_reset_a: assert property ($rose(aresetn) |-> (port6_oe | port7_oe | port8_oe) == 8'h00)
        else $error("direction not clear after reset");
    pullup_reset_a: assert property ($rose(aresetn) |-> (port1_pullup_en | port3_pullup_en | port5_pullup_en) == 8'h00)
        else $error("pull-up not clear after reset");
    dir_write_a: assert property (wr_at(A6) |-> ##2 port6_oe == $past(s_axi_wdata[7:0], 2))
        else $error("port 6 direction not written");
    dir9_write_a: assert property (wr_at(A9) |-> ##2 port9_oe == ($past(s_axi_wdata[7:0], 2) & 8'h1f))
        else $error("port 9 direction mask wrong");
    dir9_upper_a: assert property (port9_oe[7:5] == 3'h0)
        else $error("port 9 upper direction set");
    pullup_gate_a: assert property (((port1_pullup_en & $past(port1_dir_in)) | (port3_pullup_en & $past(port3_dir_in)) | (port5_pullup_en & $past(port5_dir_in))) == 8'h00)
        else $error("pull-up on output pin");
    wo_read_a: assert property (rd_at(A6) |=> s_axi_rvalid && s_axi_rdata == 32'h0)
        else $error("write-only register read nonzero");
    pu3_read_a: assert property (rd_at(A3) |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0)
        else $error("port 3 reserved bits read set");
endmodule // pdpc_port_config_assertions

bind pdpc_port_config pdpc_port_config_assertions u_chk
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .port1_dir_in(port1_dir_in), .port3_dir_in(port3_dir_in),
    .port5_dir_in(port5_dir_in), .port6_oe(port6_oe), .port7_oe(port7_oe), .port8_oe(port8_oe),
    .port9_oe(port9_oe), .port1_pullup_en(port1_pullup_en), .port3_pullup_en(port3_pullup_en),
    .port5_pullup_en(port5_pullup_en)
);

// >>> pdpc_pin_model.sv
// Far-side model of one 8-pin port.
// Assumes oe and drive come from the port's own logic on aclk.
`timescale 1ns/1ps
module pdpc_pin_model
(
    // Clock
    input  wire logic                 aclk,
    // Pin controls
    input  wire pdpc_pkg::pdpc_byte_t oe,
    input  wire pdpc_pkg::pdpc_byte_t drive,
    // Pin levels
    output pdpc_pkg::pdpc_byte_t      pin
);
    import pdpc_pkg::*;
    // Undriven pins toggle so a stale level never looks driven
    pdpc_byte_t ext_q = 8'h5a;
    always @(posedge aclk) ext_q <= ~ext_q;
    assign pin = (oe & drive) | (~oe & ext_q);
endmodule // pdpc_pin_model

// >>> pdpc_port_config_tb_top.sv
// Self-checking bench of the port configuration block.
// Assumes the package, pin model and checker are compiled first.
`timescale 1ns/1ps
module pdpc_port_config_tb_top;
    import pdpc_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    pdpc_byte_t  d1 = 8'h00, d3 = 8'h00, d5 = 8'h00, drv = 8'h00;
    pdpc_byte_t  oe6, oe7, oe8, oe9, pu1, pu3, pu5, pin6;
    pdpc_byte_t  m [7] = '{default: 8'h00};
    pdpc_byte_t  msk [7] = '{8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff};
    int          mismatches = 0, checks = 0, seed = 39887, j;
    always #25 aclk = ~aclk;
    pdpc_port_config dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port1_dir_in(d1),
        .port3_dir_in(d3), .port5_dir_in(d5), .port6_oe(oe6), .port7_oe(oe7), .port8_oe(oe8),
        .port9_oe(oe9), .port1_pullup_en(pu1), .port3_pullup_en(pu3), .port5_pullup_en(pu5)
    );
    pdpc_pin_model u_pin6 (.aclk(aclk), .oe(oe6), .drive(drv), .pin(pin6));
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expd);
        end
    endtask
    // Index 7 lands just past the map, so one loop covers the unmapped case
    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= (32'h0000_ffe9 + 32'(i)) << 2;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, i > 6 ? PDPC_RESP_SLVERR : PDPC_RESP_OKAY);
        if (i < 7 && s[0])
            m[i] = d[7:0] & msk[i];
        // One idle edge so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rdr(input int i);
        s_axi_araddr <= (32'h0000_ffe9 + 32'(i)) << 2;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, (i < 4 || i > 6) ? 32'h0 : {24'h0, m[i]});
        check(s_axi_rresp, i > 6 ? PDPC_RESP_SLVERR : PDPC_RESP_OKAY);
        // One idle edge so the next call never re-raises rready in this step
        @(posedge aclk);
    endtask
    task automatic cmp_all;
        repeat (2) @(posedge aclk);
        check(oe6, m[0]);
        check(oe7, m[1]);
        check(oe8, m[2]);
        check(oe9, m[3]);
        check(pu1, m[4] & ~d1);
        check(pu3, m[5] & ~d3);
        check(pu5, m[6] & ~d5);
        check(pin6 & oe6, drv & m[0]);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #(50 * 20000);
        mismatches++;
        final_report;
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 8; k++) rdr(k);
        cmp_all;
        $display("reset values done");
        for (int k = 0; k < 8; k++) wr(k, 32'hffff_ffff, 4'hf);
        for (int k = 0; k < 8; k++) rdr(k);
        cmp_all;
        $display("all ones done");
        for (int n = 0; n < 40; n++)
        begin
            j = $unsigned($random(seed)) % 8;
            wr(j, $random(seed), (n % 3 == 0) ? 4'he : 4'hf);
            d1 <= 8'($random(seed));
            d3 <= 8'($random(seed));
            d5 <= 8'($random(seed));
            drv <= 8'($random(seed));
            rdr(j);
            cmp_all;
        end
        $display("random traffic done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        m = '{default: 8'h00};
        cmp_all;
        $display("second reset done");
        final_report;
    end
endmodule // pdpc_port_config_tb_top
